// ==== logic/uart_frame_regs.svh ====
// Register offsets, field positions, reset values and data bit counts of the UART framer
`ifndef UART_FRAME_REGS_SVH
`define UART_FRAME_REGS_SVH
`define OFS_MODE 6'h00
`define OFS_CTRL 6'h01
`define OFS_MODE2 6'h02
`define OFS_BUF 6'h03
`define OFS_BAUD 6'h04
`define MODE_SEL_LSB 0
`define MODE_WAKE_BIT 2
`define MODE_TX9_BIT 3
`define MODE_RXEN_BIT 4
`define MODE_OD_BIT 5
`define CTRL_PAR_BIT 0
`define CTRL_EVEN_BIT 1
`define CTRL_RX9_BIT 2
`define CTRL_FULL_BIT 3
`define CTRL_PERR_BIT 4
`define CTRL_FERR_BIT 5
`define CTRL_OVR_BIT 6
`define CTRL_BUSY_BIT 7
`define MODE2_STOP_BIT 0
`define MODE_IO 2'h0
`define MODE_UART7 2'h1
`define MODE_UART8 2'h2
`define MODE_UART9 2'h3
`define BAUD_DIV_RESET 16'h0438
`define BITS_UART7 4'h7
`define BITS_UART8 4'h8
`define BITS_UART9 4'h9
`endif

// ==== logic/uart_frame_pkg.sv ====
// Types shared by the UART framer and its receiver
`include "uart_frame_regs.svh"
package uart_frame_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP} line_state_e;

   // Data bits per frame for a mode code
   function automatic logic [3:0] data_bits(input logic [1:0] mode);
      case (mode)
         `MODE_UART7: data_bits = `BITS_UART7;
         `MODE_UART8: data_bits = `BITS_UART8;
         default: data_bits = `BITS_UART9;
      endcase
   endfunction : data_bits
endpackage : uart_frame_pkg

// ==== logic/rx_link_if.sv ====
// Configuration and received frames passed between the framer and its receiver
interface rx_link_if;
   logic [15:0] div;
   logic [1:0] mode;
   logic parity_on;
   logic even;
   logic rx_en;
   logic done;
   logic [8:0] data;
   logic perr;
   logic ferr;
   modport core (output div, mode, parity_on, even, rx_en, input done, data, perr, ferr);
   modport rx (input div, mode, parity_on, even, rx_en, output done, data, perr, ferr);
endinterface : rx_link_if

// ==== logic/uart_frame_rx.sv ====
// Asynchronous frame receiver for the 7, 8 and 9 bit UART modes
`include "uart_frame_regs.svh"
module uart_frame_rx (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic serial_in_pin_i,
   rx_link_if.rx link
);
   typedef struct packed {
      uart_frame_pkg::line_state_e st;
      logic [15:0] cnt;
      logic [3:0] idx;
      logic [8:0] sh;
      logic perr;
      logic done;
      logic ferr;
   } rx_s;

   rx_s q_ff;
   rx_s nxt_q;
   logic [3:0] nbits;
   logic bit_end;
   logic par_calc;

   assign nbits = uart_frame_pkg::data_bits(link.mode);
   assign bit_end = (q_ff.cnt == link.div - 16'h0001);
   // Parity expected on the bits gathered so far
   assign par_calc = link.even ? (^q_ff.sh) : ~(^q_ff.sh);

   // Receive sequencer, one sample in the middle of each bit
   always_comb begin
      nxt_q = q_ff;
      nxt_q.done = 1'b0;
      nxt_q.cnt = q_ff.cnt + 16'h0001;
      case (q_ff.st)
         uart_frame_pkg::ST_IDLE: begin
            nxt_q.cnt = 16'h0000;
            if (link.rx_en && link.mode != `MODE_IO && !serial_in_pin_i) begin
               nxt_q.st = uart_frame_pkg::ST_START;
            end
         end
         uart_frame_pkg::ST_START: begin
            if (q_ff.cnt == {1'b0, link.div[15:1]}) begin
               nxt_q.cnt = 16'h0000;
               nxt_q.idx = 4'h0;
               nxt_q.sh = 9'h000;
               // Glitch shorter than half a bit is dropped
               nxt_q.st = serial_in_pin_i ? uart_frame_pkg::ST_IDLE : uart_frame_pkg::ST_DATA;
            end
         end
         uart_frame_pkg::ST_DATA: begin
            if (bit_end) begin
               nxt_q.cnt = 16'h0000;
               nxt_q.sh[q_ff.idx] = serial_in_pin_i;
               nxt_q.idx = q_ff.idx + 4'h1;
               if (q_ff.idx == nbits - 4'h1) begin
                  // No parity in nine bit mode
                  if (link.parity_on && link.mode != `MODE_UART9) begin
                     nxt_q.st = uart_frame_pkg::ST_PARITY;
                  end else begin
                     nxt_q.st = uart_frame_pkg::ST_STOP;
                  end
               end
            end
         end
         uart_frame_pkg::ST_PARITY: begin
            if (bit_end) begin
               nxt_q.cnt = 16'h0000;
               nxt_q.perr = (serial_in_pin_i != par_calc);
               nxt_q.st = uart_frame_pkg::ST_STOP;
            end
         end
         uart_frame_pkg::ST_STOP: begin
            if (bit_end) begin
               // Only the first stop bit is checked; a second one reads as idle
               nxt_q.ferr = !serial_in_pin_i;
               nxt_q.done = 1'b1;
               nxt_q.st = uart_frame_pkg::ST_IDLE;
            end
         end
         default: nxt_q.st = uart_frame_pkg::ST_IDLE;
      endcase
      if (q_ff.st != uart_frame_pkg::ST_PARITY && q_ff.st != uart_frame_pkg::ST_STOP) begin
         if (q_ff.st == uart_frame_pkg::ST_START) begin
            nxt_q.perr = 1'b0;
         end
      end
      if (rst_i) begin
         nxt_q = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      q_ff <= nxt_q;
   end

   // Results toward the framer
   assign link.done = q_ff.done;
   assign link.data = q_ff.sh;
   assign link.perr = q_ff.perr;
   assign link.ferr = q_ff.ferr;
endmodule : uart_frame_rx

// ==== logic/uart_frame_modes.sv ====
// UART framer top: Wishbone registers, transmitter and receiver hookup
// What this block does
// - Mode 01 gives seven data bits
// - Optional even or odd parity bit
// - Stop bit count from stop select
// - Mode 10 gives eight data bits
// - Mode 11 gives nine data bits
// - Nine bit mode carries no parity
// - Transmit ninth bit sent as MSB
// - Received ninth bit kept in control
// - Wake-up in mode 11 passes only ninth-bit-one frames
//
// Our own choices: the address map and the Wishbone register port.
`include "uart_frame_regs.svh"
module uart_frame_modes (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic serial_in_pin_i,
   output logic serial_out_pin_o,
   output logic serial_out_pin_oe_o,
   output logic receive_interrupt_o,
   output logic transmit_interrupt_o
);
   typedef struct packed {
      logic [1:0] mode_sel;
      logic wake_en;
      logic tx_ninth_bit;
      logic rx_en;
      logic open_drain_select;
      logic parity_on;
      logic even;
      logic stop_length_select;
      logic [15:0] div;
      logic [7:0] rx_data;
      logic rx_ninth_bit;
      logic rx_full;
      logic perr;
      logic ferr;
      logic overrun;
      logic ack;
      logic [31:0] dat;
      uart_frame_pkg::line_state_e tx_st;
      logic [8:0] tx_sh;
      logic tx_par;
      logic [3:0] tx_idx;
      logic [15:0] baud;
      logic line;
      logic oe;
      logic pin;
      logic rx_evt;
      logic tx_evt;
   } core_s;

   core_s q_ff;
   core_s nxt_q;
   rx_link_if link ();
   logic req;
   logic wr;
   logic rd;
   logic [5:0] idx;
   logic [3:0] nbits;
   logic [8:0] mask;
   logic tick;
   logic keep_frame;
   logic [7:0] mode_rd;
   logic [7:0] ctrl_rd;

   uart_frame_rx u_rx (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .serial_in_pin_i(serial_in_pin_i),
      .link(link)
   );

   // Configuration toward the receiver
   assign link.div = q_ff.div;
   assign link.mode = q_ff.mode_sel;
   assign link.parity_on = q_ff.parity_on;
   assign link.even = q_ff.even;
   assign link.rx_en = q_ff.rx_en;

   // Bus decode; one-cycle ack keeps every access at a fixed latency
   assign req = wb_cyc_i && wb_stb_i && !q_ff.ack;
   assign wr = req && wb_we_i;
   assign rd = req && !wb_we_i;
   assign idx = wb_adr_i[7:2];
   assign nbits = uart_frame_pkg::data_bits(q_ff.mode_sel);
   assign mask = 9'h1ff >> (4'h9 - nbits);
   assign tick = (q_ff.baud == q_ff.div - 16'h0001);
   assign keep_frame = !(q_ff.wake_en && q_ff.mode_sel == `MODE_UART9 && !link.data[8]);

   // Readback images of the mode and control registers
   always_comb begin
      mode_rd = 8'h00;
      mode_rd[`MODE_SEL_LSB +: 2] = q_ff.mode_sel;
      mode_rd[`MODE_WAKE_BIT] = q_ff.wake_en;
      mode_rd[`MODE_TX9_BIT] = q_ff.tx_ninth_bit;
      mode_rd[`MODE_RXEN_BIT] = q_ff.rx_en;
      mode_rd[`MODE_OD_BIT] = q_ff.open_drain_select;
      ctrl_rd = 8'h00;
      ctrl_rd[`CTRL_PAR_BIT] = q_ff.parity_on;
      ctrl_rd[`CTRL_EVEN_BIT] = q_ff.even;
      ctrl_rd[`CTRL_RX9_BIT] = q_ff.rx_ninth_bit;
      ctrl_rd[`CTRL_FULL_BIT] = q_ff.rx_full;
      ctrl_rd[`CTRL_PERR_BIT] = q_ff.perr;
      ctrl_rd[`CTRL_FERR_BIT] = q_ff.ferr;
      ctrl_rd[`CTRL_OVR_BIT] = q_ff.overrun;
      ctrl_rd[`CTRL_BUSY_BIT] = (q_ff.tx_st != uart_frame_pkg::ST_IDLE);
   end

   // Whole next state: bus, receive capture and transmit sequencer
   always_comb begin
      nxt_q = q_ff;
      nxt_q.ack = req;
      nxt_q.rx_evt = 1'b0;
      nxt_q.tx_evt = 1'b0;
      if (rd) begin
         case (idx)
            `OFS_MODE: nxt_q.dat = {24'h00_0000, mode_rd};
            `OFS_CTRL: nxt_q.dat = {24'h00_0000, ctrl_rd};
            `OFS_MODE2: nxt_q.dat = {31'h0000_0000, q_ff.stop_length_select};
            `OFS_BUF: nxt_q.dat = {24'h00_0000, q_ff.rx_data};
            `OFS_BAUD: nxt_q.dat = {16'h0000, q_ff.div};
            default: nxt_q.dat = 32'h0000_0000;
         endcase
         // Reading the buffer releases it; the overrun flag goes with it, parity and framing errors stay
         if (idx == `OFS_BUF) begin
            nxt_q.rx_full = 1'b0;
            nxt_q.overrun = 1'b0;
         end
      end
      if (wr && wb_sel_i[0]) begin
         case (idx)
            `OFS_MODE: begin
               nxt_q.mode_sel = wb_dat_i[`MODE_SEL_LSB +: 2];
               nxt_q.wake_en = wb_dat_i[`MODE_WAKE_BIT];
               // Ninth bit staged before buffer write
               nxt_q.tx_ninth_bit = wb_dat_i[`MODE_TX9_BIT];
               nxt_q.rx_en = wb_dat_i[`MODE_RXEN_BIT];
               nxt_q.open_drain_select = wb_dat_i[`MODE_OD_BIT];
            end
            `OFS_CTRL: begin
               nxt_q.parity_on = wb_dat_i[`CTRL_PAR_BIT];
               nxt_q.even = wb_dat_i[`CTRL_EVEN_BIT];
            end
            `OFS_MODE2: nxt_q.stop_length_select = wb_dat_i[`MODE2_STOP_BIT];
            `OFS_BAUD: nxt_q.div[7:0] = wb_dat_i[7:0];
            default: nxt_q.dat = q_ff.dat;
         endcase
      end
      if (wr && wb_sel_i[1] && idx == `OFS_BAUD) begin
         nxt_q.div[15:8] = wb_dat_i[15:8];
      end
      // Frame capture; a new frame wins over a same-cycle buffer read
      if (link.done && keep_frame) begin
         // Ninth bit to control, low byte to buffer
         nxt_q.rx_data = link.data[7:0];
         nxt_q.rx_ninth_bit = (q_ff.mode_sel == `MODE_UART9) ? link.data[8] : 1'b0;
         nxt_q.perr = link.perr;
         nxt_q.ferr = link.ferr;
         nxt_q.overrun = q_ff.rx_full;
         nxt_q.rx_full = 1'b1;
         nxt_q.rx_evt = 1'b1;
      end
      // Transmit sequencer, one bit per divisor period
      nxt_q.baud = (q_ff.tx_st == uart_frame_pkg::ST_IDLE || tick) ? 16'h0000 :
                   q_ff.baud + 16'h0001;
      case (q_ff.tx_st)
         uart_frame_pkg::ST_IDLE: begin
            nxt_q.line = 1'b1;
            // Buffer writes during a frame are dropped; poll busy first
            if (wr && wb_sel_i[0] && idx == `OFS_BUF && q_ff.mode_sel != `MODE_IO) begin
               // Ninth bit on top of the byte
               nxt_q.tx_sh = {q_ff.tx_ninth_bit, wb_dat_i[7:0]} & mask;
               nxt_q.tx_par = q_ff.even ? (^(wb_dat_i[7:0] & mask[7:0])) :
                              ~(^(wb_dat_i[7:0] & mask[7:0]));
               nxt_q.tx_idx = 4'h0;
               nxt_q.line = 1'b0;
               nxt_q.tx_st = uart_frame_pkg::ST_START;
            end
         end
         uart_frame_pkg::ST_START: begin
            if (tick) begin
               nxt_q.line = q_ff.tx_sh[0];
               nxt_q.tx_sh = {1'b0, q_ff.tx_sh[8:1]};
               nxt_q.tx_st = uart_frame_pkg::ST_DATA;
            end
         end
         uart_frame_pkg::ST_DATA: begin
            if (tick) begin
               nxt_q.tx_idx = q_ff.tx_idx + 4'h1;
               nxt_q.line = q_ff.tx_sh[0];
               nxt_q.tx_sh = {1'b0, q_ff.tx_sh[8:1]};
               if (q_ff.tx_idx == nbits - 4'h1) begin
                  nxt_q.tx_idx = 4'h0;
                  // Parity bit outside nine bit mode
                  if (q_ff.parity_on && q_ff.mode_sel != `MODE_UART9) begin
                     nxt_q.line = q_ff.tx_par;
                     nxt_q.tx_st = uart_frame_pkg::ST_PARITY;
                  end else begin
                     nxt_q.line = 1'b1;
                     nxt_q.tx_st = uart_frame_pkg::ST_STOP;
                  end
               end
            end
         end
         uart_frame_pkg::ST_PARITY: begin
            if (tick) begin
               nxt_q.line = 1'b1;
               nxt_q.tx_st = uart_frame_pkg::ST_STOP;
            end
         end
         uart_frame_pkg::ST_STOP: begin
            if (tick) begin
               nxt_q.tx_idx = q_ff.tx_idx + 4'h1;
               if (q_ff.tx_idx == {3'h0, q_ff.stop_length_select}) begin
                  nxt_q.tx_evt = 1'b1;
                  nxt_q.tx_st = uart_frame_pkg::ST_IDLE;
               end
            end
         end
         default: nxt_q.tx_st = uart_frame_pkg::ST_IDLE;
      endcase
      // Pin and enable share one select copy, so a mode switch never glitches low
      // Open-drain drives only low; the pull-up makes the high level
      nxt_q.oe = nxt_q.open_drain_select ? !nxt_q.line : 1'b1;
      nxt_q.pin = nxt_q.open_drain_select ? 1'b0 : nxt_q.line;
      if (rst_i) begin
         nxt_q = '0;
         nxt_q.div = `BAUD_DIV_RESET;
         nxt_q.line = 1'b1;
         nxt_q.oe = 1'b1;
         nxt_q.pin = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      q_ff <= nxt_q;
   end

   // Outputs straight from the state register
   assign wb_dat_o = q_ff.dat;
   assign wb_ack_o = q_ff.ack;
   // Open-drain option for shared return line
   assign serial_out_pin_o = q_ff.pin;
   assign serial_out_pin_oe_o = q_ff.oe;
   assign receive_interrupt_o = q_ff.rx_evt;
   assign transmit_interrupt_o = q_ff.tx_evt;
endmodule : uart_frame_modes

// ==== tb/uart_frame_modes_chk.sv ====
// Port-level checks for the UART framer top
module uart_frame_modes_chk (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic serial_out_pin_o,
   input wire logic serial_out_pin_oe_o,
   input wire logic receive_interrupt_o,
   input wire logic transmit_interrupt_o
);
   timeunit 1ns;
   timeprecision 1ps;
   wire logic line;
   // Wire level, pull-up when released
   assign line = serial_out_pin_oe_o ? serial_out_pin_o : 1'b1;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered next cycle");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_rdata_held: assert property (!(wb_ack_o && !wb_we_i) |-> $stable(wb_dat_o))
      else $error("read data moved outside a read");
   a_quiet_start: assert property ($past(rst_i) |-> !wb_ack_o && line && !transmit_interrupt_o)
      else $error("not idle after reset");
   a_tx_pulse: assert property (transmit_interrupt_o |=> !transmit_interrupt_o)
      else $error("transmit pulse too long");
   a_rx_pulse: assert property (receive_interrupt_o |=> !receive_interrupt_o)
      else $error("receive pulse too long");
   a_stop_high: assert property (transmit_interrupt_o |-> $past(line, 1) && line)
      else $error("line low at end of frame");
   a_od_release: assert property (!serial_out_pin_oe_o |-> !serial_out_pin_o)
      else $error("released pin carries a one");
   a_start_width: assert property ($fell(line) |=> !line)
      else $error("start bit too short");
   c_tx_done: cover property (transmit_interrupt_o);
   c_rx_kept: cover property (receive_interrupt_o);
   c_bus_read: cover property (wb_ack_o && !wb_we_i);
endmodule : uart_frame_modes_chk

bind uart_frame_modes uart_frame_modes_chk chk (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .serial_out_pin_o(serial_out_pin_o),
   .serial_out_pin_oe_o(serial_out_pin_oe_o), .receive_interrupt_o(receive_interrupt_o),
   .transmit_interrupt_o(transmit_interrupt_o));

// ==== tb/uart_line_partner.sv ====
// Far-side UART model: frame sender and wire capture
module uart_line_partner (
   input wire logic clk_i,
   input wire logic line_i,
   output logic line_o,
   input wire logic [15:0] div_i,
   input wire logic [3:0] n_i,
   output logic [11:0] cap_o,
   output logic [7:0] got_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      line_o = 1'b1;
      cap_o = '0;
      got_o = '0;
   end
   // Capture n bits after a start, sampled mid-bit
   initial begin
      logic [11:0] c;
      forever begin
         @(posedge clk_i);
         if (line_i === 1'b0) begin
            c = '0;
            repeat (div_i / 2) @(posedge clk_i);
            for (int b = 0; b < n_i; b++) begin
               repeat (div_i) @(posedge clk_i);
               c[b] = line_i;
            end
            cap_o <= c;
            got_o <= got_o + 8'h1;
         end
      end
   end
   task automatic send(input logic [11:0] bits, input int n);
      @(posedge clk_i);
      line_o <= 1'b0;
      repeat (div_i) @(posedge clk_i);
      for (int b = 0; b < n; b++) begin
         line_o <= bits[b];
         repeat (div_i) @(posedge clk_i);
      end
      line_o <= 1'b1;
   endtask : send
endmodule : uart_line_partner

// ==== tb/tb_uart_frame_modes.sv ====
// Self-checking bench for the UART framer
`include "uart_frame_regs.svh"
module tb_uart_frame_modes;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i, rst_i, cyc, stb, we;
   logic [7:0] adr;
   logic [3:0] sel, pn;
   logic [31:0] wdat, q;
   wire logic [31:0] rdat;
   wire logic ack, txo, txoe, rxi, tx_irq, rx_irq;
   wire logic [11:0] cap;
   wire logic [7:0] got;
   int err_total, total_checks, seed, cycles, tx_cnt, rx_cnt;
   wire logic line = txoe ? txo : 1'b1;
   uart_frame_modes dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .serial_in_pin_i(rxi), .serial_out_pin_o(txo),
      .serial_out_pin_oe_o(txoe), .receive_interrupt_o(rx_irq),
      .transmit_interrupt_o(tx_irq));
   uart_line_partner peer (.clk_i(clk_i), .line_i(line), .line_o(rxi), .div_i(16'h0008),
      .n_i(pn), .cap_o(cap), .got_o(got));
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   // Event counters and hang guard
   always @(posedge clk_i) begin
      cycles++;
      tx_cnt += int'(tx_irq === 1'b1);
      rx_cnt += int'(rx_irq === 1'b1);
      if (cycles == 20000) begin
         err_total++;
         conclude();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", nm, e, g);
         err_total++;
      end
   endtask : chk
   // Classic cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {a, 2'b00};
      wdat <= d;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1 && k < 50);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (k >= 50) err_total++;
   endtask : wb
   task automatic await(ref int c, input int c0);
      int k;
      k = 0;
      while (c == c0 && k < 400) begin
         @(posedge clk_i);
         k++;
      end
      chk("event count", 32'(c0 + 1), 32'(c));
   endtask : await
   // Expected wire bits, stops included, masked to length
   function automatic logic [11:0] frame(input logic [1:0] m, input logic p, e, s,
         input logic [8:0] d, output int n);
      logic par;
      logic [11:0] f;
      par = 1'b0;
      f = '1;
      n = 6 + int'(m);
      for (int i = 0; i < n; i++) begin
         f[i] = d[i];
         par ^= d[i];
      end
      if (p && m != 2'd3) begin
         f[n] = e ? par : !par;
         n++;
      end
      n += s ? 2 : 1;
      return f & ((12'h1 << n) - 12'h1);
   endfunction : frame
   task automatic run_case(input logic [1:0] m, input logic p, e, s, od, input logic [8:0] d);
      int c0, n;
      logic [11:0] f;
      logic [7:0] g0;
      f = frame(m, p, e, s, d, n);
      pn <= 4'(n);
      // Software keeps parity off in nine bit mode
      wb(1'b1, `OFS_CTRL, {30'h0, e, p && m != 2'd3});
      wb(1'b1, `OFS_MODE2, {31'h0, s});
      wb(1'b1, `OFS_MODE, {26'h0, od, 1'b0, d[8], 1'b0, m});
      c0 = tx_cnt;
      g0 = got;
      wb(1'b1, `OFS_BUF, {24'h0, d[7:0]});
      await(tx_cnt, c0);
      chk("tx frame", {20'h0, f}, {20'h0, cap});
      chk("peer frames", {24'h0, g0 + 8'h1}, {24'h0, got});
      wb(1'b1, `OFS_MODE, {27'h0, 1'b1, 2'b00, m});
      c0 = rx_cnt;
      peer.send(f, n);
      await(rx_cnt, c0);
      wb(1'b0, `OFS_CTRL, 32'h0);
      chk("rx ctrl", {24'h0, 4'h0, 1'b1, m == 2'd3 && d[8], e, p && m != 2'd3},
         {24'h0, q[7:0]});
      wb(1'b0, `OFS_BUF, 32'h0);
      chk("rx data", {24'h0, d[7:0] & (m == 2'd1 ? 8'h7F : 8'hFF)}, q);
   endtask : run_case
   task automatic wake(input logic [8:0] d, input logic kept);
      int c0, n;
      logic [11:0] f;
      f = frame(2'd3, 1'b0, 1'b0, 1'b0, d, n);
      c0 = rx_cnt;
      peer.send(f, n);
      repeat (30) @(posedge clk_i);
      chk("wake count", 32'(c0 + int'(kept)), 32'(rx_cnt));
      if (kept) begin
         wb(1'b0, `OFS_CTRL, 32'h0);
         chk("wake ctrl", {29'h0, d[8], 2'b00}, {29'h0, q[2:0]});
         wb(1'b0, `OFS_BUF, 32'h0);
         chk("wake data", {24'h0, d[7:0]}, q);
      end
   endtask : wake
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : conclude
   initial begin
      seed = 46488;
      {cyc, stb, we, adr, wdat, pn} = '0;
      sel = 4'hF;
      rst_i = 1'b1;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, `OFS_MODE, 32'h0);
      chk("mode reset", 32'h0, q);
      wb(1'b0, `OFS_BAUD, 32'h0);
      chk("baud reset", {16'h0, `BAUD_DIV_RESET}, q);
      wb(1'b0, 6'h20, 32'h0);
      chk("unmapped", 32'h0, q);
      wb(1'b1, `OFS_BAUD, 32'h0000_0008);
      run_case(`MODE_UART9, 1'b1, 1'b1, 1'b1, 1'b0, 9'h1FF);
      run_case(`MODE_UART7, 1'b1, 1'b0, 1'b1, 1'b1, 9'h080);
      $display("test corners done");
      for (int k = 0; k < 12; k++) begin
         run_case(2'(k % 3 + 1), 1'($random(seed)), 1'($random(seed)), 1'($random(seed)),
            1'($random(seed)), 9'($random(seed)));
         $display("test %0d done", k);
      end
      wb(1'b1, `OFS_CTRL, 32'h0);
      wb(1'b1, `OFS_MODE, 32'h0000_0017);
      wake(9'h0A5, 1'b0);
      wake(9'h1C3, 1'b1);
      wb(1'b1, `OFS_MODE, 32'h0000_0013);
      wake(9'h03C, 1'b1);
      $display("test wake done");
      conclude();
   end
endmodule : tb_uart_frame_modes
